// file: rtl/flash_status_regs.svh
// register offsets, field positions, reset values and timing counts of the status poller
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

// ----------------------------------------
// register word offsets (byte address)
// ----------------------------------------
`define FS_OFF_CTRL 8'h00
`define FS_OFF_ADDR 8'h04
`define FS_OFF_STATUS 8'h08
`define FS_OFF_LIMIT 8'h0C
`define FS_OFF_DATA 8'h10

// ----------------------------------------
// control fields (write pulses)
// ----------------------------------------
`define FS_CTRL_POLL 0
`define FS_CTRL_ADD_ERASE 1
`define FS_CTRL_RESET 2
`define FS_CTRL_SKIP_TIMER 3

// ----------------------------------------
// status fields
// ----------------------------------------
`define FS_ST_BUSY 0
`define FS_ST_OK 1
`define FS_ST_FAIL 2
`define FS_ST_LEFT 3
`define FS_ST_SECT_SEL 4
`define FS_ST_SUSPENDED 5
`define FS_ST_TIMER_PRE 6
`define FS_ST_TIMER_POST 7
`define FS_ST_MAY_REJECT 8
`define FS_ST_NOT_ACCEPTED 9
`define FS_ST_READY_PIN 10

// ----------------------------------------
// reset values
// ----------------------------------------
`define FS_RST_ADDR 22'h00_0000
`define FS_RST_LIMIT 16'h0000
`define FS_RST_WORD 16'h0000

// ----------------------------------------
// data bus status bit positions
// ----------------------------------------
`define FS_DQ_POLLING 7
`define FS_DQ_FIRST_TOGGLE 6
`define FS_DQ_TIMEOUT 5
`define FS_DQ_ERASE_TIMER 3
`define FS_DQ_SECOND_TOGGLE 2

// ----------------------------------------
// command words
// ----------------------------------------
`define FS_CMD_RESET 16'h00F0
`define FS_CMD_SECT_ERASE 16'h0030

// ----------------------------------------
// timing
// ----------------------------------------
`define FS_CLK_NS 8
`define FS_STROBE_NS 70
`define FS_STROBE_CYC 4'(((`FS_STROBE_NS) + (`FS_CLK_NS) - 1) / (`FS_CLK_NS))

`endif

// file: rtl/flash_status_pkg.sv
// types shared by the status poller and its bus cycle engine
package flash_status_pkg;

    typedef logic [21:0] flash_addr_t;
    typedef logic [15:0] flash_word_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SETUP = 2'b01,
        PH_STROBE = 2'b10,
        PH_HOLD = 2'b11
    } cycle_phase_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_RD1 = 4'b0001,
        ST_RD2 = 4'b0010,
        ST_RD3 = 4'b0011,
        ST_RD4 = 4'b0100,
        ST_ARRAY = 4'b0101,
        ST_RESET = 4'b0110,
        ST_CHK_PRE1 = 4'b0111,
        ST_CHK_PRE2 = 4'b1000,
        ST_ERASE_CMD = 4'b1001,
        ST_CHK_POST = 4'b1010
    } poll_state_e;

endpackage

// file: rtl/flash_bus_cycle.sv
// one asynchronous flash read or write cycle, paced from mclk
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_regs.svh"

module flash_bus_cycle (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic start,
    input wire logic isWrite,
    input wire flash_status_pkg::flash_addr_t addrIn,
    input wire flash_status_pkg::flash_word_t wdata,
    output logic done,
    output flash_status_pkg::flash_word_t rdata,
    output flash_status_pkg::flash_addr_t flashAddr,
    output flash_status_pkg::flash_word_t flashDqOut,
    output logic flashDqOe,
    input wire flash_status_pkg::flash_word_t flashDqIn,
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN
);
    import flash_status_pkg::*;

    cycle_phase_e phase_reg;
    logic [3:0] cnt_reg;
    logic write_reg;

    // ----------------------------------------
    // phase sequencing
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            phase_reg <= PH_IDLE;
            cnt_reg <= 4'h0;
            write_reg <= 1'b0;
            done <= 1'b0;
        end else if (clkEn) begin
            done <= 1'b0;
            case (phase_reg)
                PH_IDLE: begin
                    if (start) begin
                        phase_reg <= PH_SETUP;
                        write_reg <= isWrite;
                    end
                end
                PH_SETUP: begin
                    phase_reg <= PH_STROBE;
                    cnt_reg <= `FS_STROBE_CYC;
                end
                PH_STROBE: begin
                    if (cnt_reg == 4'h1) begin
                        phase_reg <= PH_HOLD;
                    end
                    cnt_reg <= cnt_reg - 4'h1;
                end
                PH_HOLD: begin
                    phase_reg <= PH_IDLE;
                    done <= 1'b1;
                end
                default: phase_reg <= PH_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    // address and data are held one cycle past the strobe so the rising edge of
    // write enable or output enable never races an address change
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            flashAddr <= 22'h00_0000;
            flashDqOut <= 16'h0000;
            flashDqOe <= 1'b0;
            flashCeN <= 1'b1;
            flashOeN <= 1'b1;
            flashWeN <= 1'b1;
            rdata <= 16'h0000;
        end else if (clkEn) begin
            if (phase_reg == PH_IDLE && start) begin
                flashAddr <= addrIn;
                flashDqOut <= wdata;
                flashDqOe <= isWrite;
                flashCeN <= 1'b0;
            end
            if (phase_reg == PH_SETUP) begin
                flashOeN <= write_reg;
                flashWeN <= !write_reg;
            end
            if (phase_reg == PH_STROBE && cnt_reg == 4'h1) begin
                flashOeN <= 1'b1;
                flashWeN <= 1'b1;
                if (!write_reg) begin
                    rdata <= flashDqIn;
                end
            end
            if (phase_reg == PH_HOLD) begin
                flashCeN <= 1'b1;
                flashDqOe <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/flash_status_poller.sv
// host-side write-status poller for a parallel nor flash, wishbone controlled
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_regs.svh"

module flash_status_poller (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output flash_status_pkg::flash_addr_t flashAddr,
    output flash_status_pkg::flash_word_t flashDqOut,
    output logic flashDqOe,
    input wire flash_status_pkg::flash_word_t flashDqIn,
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    input wire logic readyBusyN
);
    import flash_status_pkg::*;

    poll_state_e state_reg;
    flash_addr_t addr_reg;
    flash_word_t limit_reg;
    flash_word_t count_reg;
    flash_word_t first_reg;
    flash_word_t data_reg;
    logic issued_reg;
    logic skip_reg;
    logic okFlag_reg;
    logic failFlag_reg;
    logic leftFlag_reg;
    logic sectSel_reg;
    logic suspended_reg;
    logic timerPre_reg;
    logic timerPost_reg;
    logic mayReject_reg;
    logic notAccepted_reg;
    logic cycStart;
    logic cycWrite;
    logic cycDone;
    flash_word_t cycData;
    flash_word_t rdata;
    logic wbWrite;
    logic firstToggles;
    logic secondToggles;
    logic [31:0] statusWord;

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    assign wbWrite = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_o <= 1'b0;
        end else if (clkEn) begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            addr_reg <= `FS_RST_ADDR;
            limit_reg <= `FS_RST_LIMIT;
        end else if (clkEn && wbWrite) begin
            if (adr_i == `FS_OFF_ADDR) begin
                addr_reg <= dat_i[21:0];
            end else if (adr_i == `FS_OFF_LIMIT) begin
                limit_reg <= dat_i[15:0];
            end
        end
    end

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[`FS_ST_BUSY] = state_reg != ST_IDLE;
        statusWord[`FS_ST_OK] = okFlag_reg;
        statusWord[`FS_ST_FAIL] = failFlag_reg;
        statusWord[`FS_ST_LEFT] = leftFlag_reg;
        statusWord[`FS_ST_SECT_SEL] = sectSel_reg;
        statusWord[`FS_ST_SUSPENDED] = suspended_reg;
        statusWord[`FS_ST_TIMER_PRE] = timerPre_reg;
        statusWord[`FS_ST_TIMER_POST] = timerPost_reg;
        statusWord[`FS_ST_MAY_REJECT] = mayReject_reg;
        statusWord[`FS_ST_NOT_ACCEPTED] = notAccepted_reg;
        statusWord[`FS_ST_READY_PIN] = readyBusyN;
        statusWord[31:16] = count_reg;
    end

    // unmapped offsets read as zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dat_o <= 32'h0000_0000;
        end else if (clkEn && cyc_i && stb_i && !ack_o) begin
            if (adr_i == `FS_OFF_ADDR) begin
                dat_o <= {10'h000, addr_reg};
            end else if (adr_i == `FS_OFF_STATUS) begin
                dat_o <= statusWord;
            end else if (adr_i == `FS_OFF_LIMIT) begin
                dat_o <= {16'h0000, limit_reg};
            end else if (adr_i == `FS_OFF_DATA) begin
                dat_o <= {16'h0000, data_reg};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // flash cycle requests
    // ----------------------------------------
    // every status read and command goes to the programmed bank address
    always_comb begin
        cycStart = (state_reg != ST_IDLE) && !issued_reg;
        cycWrite = (state_reg == ST_RESET) || (state_reg == ST_ERASE_CMD);
        cycData = (state_reg == ST_RESET) ? `FS_CMD_RESET : `FS_CMD_SECT_ERASE;
    end

    assign firstToggles = rdata[`FS_DQ_FIRST_TOGGLE] != first_reg[`FS_DQ_FIRST_TOGGLE];
    assign secondToggles = rdata[`FS_DQ_SECOND_TOGGLE] != first_reg[`FS_DQ_SECOND_TOGGLE];

    flash_bus_cycle cycleEngine (
        .mclk(mclk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .start(cycStart),
        .isWrite(cycWrite),
        .addrIn(addr_reg),
        .wdata(cycData),
        .done(cycDone),
        .rdata(rdata),
        .flashAddr(flashAddr),
        .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe),
        .flashDqIn(flashDqIn),
        .flashCeN(flashCeN),
        .flashOeN(flashOeN),
        .flashWeN(flashWeN)
    );

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            issued_reg <= 1'b0;
        end else if (clkEn) begin
            if (cycDone) begin
                issued_reg <= 1'b0;
            end else if (cycStart) begin
                issued_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // polling sequencer
    // ----------------------------------------
    // commands written while busy are dropped; the status word shows busy
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            skip_reg <= 1'b0;
            count_reg <= 16'h0000;
            first_reg <= `FS_RST_WORD;
            data_reg <= `FS_RST_WORD;
        end else if (clkEn) begin
            case (state_reg)
                ST_IDLE: begin
                    if (wbWrite && adr_i == `FS_OFF_CTRL) begin
                        count_reg <= 16'h0000;
                        skip_reg <= dat_i[`FS_CTRL_SKIP_TIMER];
                        if (dat_i[`FS_CTRL_POLL]) begin
                            state_reg <= ST_RD1;
                        end else if (dat_i[`FS_CTRL_ADD_ERASE]) begin
                            state_reg <= dat_i[`FS_CTRL_SKIP_TIMER] ? ST_ERASE_CMD : ST_CHK_PRE1;
                        end else if (dat_i[`FS_CTRL_RESET]) begin
                            state_reg <= ST_RESET;
                        end
                    end
                end
                ST_RD1, ST_RD3, ST_CHK_PRE1: begin
                    if (cycDone) begin
                        first_reg <= rdata;
                        state_reg <= poll_state_e'(state_reg + 4'h1);
                    end
                end
                ST_RD2: begin
                    if (cycDone) begin
                        if (!firstToggles) begin
                            state_reg <= ST_ARRAY;
                        end else if (rdata[`FS_DQ_TIMEOUT]) begin
                            state_reg <= ST_RD3;
                        end else begin
                            count_reg <= count_reg + 16'h0001;
                            // leaving means the next poll command starts over at the first read
                            state_reg <= (limit_reg != 16'h0000 && count_reg + 16'h0001 >= limit_reg) ?
                                ST_IDLE : ST_RD1;
                        end
                    end
                end
                ST_RD4: begin
                    if (cycDone) begin
                        state_reg <= firstToggles ? ST_RESET : ST_ARRAY;
                    end
                end
                ST_ARRAY: begin
                    if (cycDone) begin
                        data_reg <= rdata;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_CHK_PRE2: begin
                    if (cycDone) begin
                        // a high timer flag means the window has closed; sending more would be ignored
                        state_reg <= rdata[`FS_DQ_ERASE_TIMER] ? ST_IDLE : ST_ERASE_CMD;
                    end
                end
                ST_ERASE_CMD: begin
                    if (cycDone) begin
                        state_reg <= skip_reg ? ST_IDLE : ST_CHK_POST;
                    end
                end
                ST_RESET, ST_CHK_POST: begin
                    if (cycDone) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // result flags, cleared when a new command starts
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            okFlag_reg <= 1'b0;
            failFlag_reg <= 1'b0;
            leftFlag_reg <= 1'b0;
            sectSel_reg <= 1'b0;
            suspended_reg <= 1'b0;
            timerPre_reg <= 1'b0;
            timerPost_reg <= 1'b0;
            mayReject_reg <= 1'b0;
            notAccepted_reg <= 1'b0;
        end else if (clkEn) begin
            if (state_reg == ST_IDLE && wbWrite && adr_i == `FS_OFF_CTRL) begin
                okFlag_reg <= 1'b0;
                failFlag_reg <= 1'b0;
                leftFlag_reg <= 1'b0;
                sectSel_reg <= 1'b0;
                suspended_reg <= 1'b0;
                timerPre_reg <= 1'b0;
                timerPost_reg <= 1'b0;
                mayReject_reg <= 1'b0;
                notAccepted_reg <= 1'b0;
            end
            if (cycDone && state_reg == ST_RD2) begin
                sectSel_reg <= secondToggles;
                suspended_reg <= !firstToggles && secondToggles;
                okFlag_reg <= !firstToggles;
                leftFlag_reg <= firstToggles && !rdata[`FS_DQ_TIMEOUT] &&
                    limit_reg != 16'h0000 && count_reg + 16'h0001 >= limit_reg;
            end
            if (cycDone && state_reg == ST_RD4) begin
                okFlag_reg <= !firstToggles;
                failFlag_reg <= firstToggles;
            end
            if (cycDone && state_reg == ST_CHK_PRE2) begin
                notAccepted_reg <= !firstToggles;
                timerPre_reg <= rdata[`FS_DQ_ERASE_TIMER];
            end
            if (cycDone && state_reg == ST_CHK_POST) begin
                timerPost_reg <= rdata[`FS_DQ_ERASE_TIMER];
                mayReject_reg <= rdata[`FS_DQ_ERASE_TIMER];
            end
        end
    end

endmodule
`default_nettype wire

// file: sim/flash_status_poller_asserts.sv
// port checker for the flash status poller
`timescale 1ns/100ps
`default_nettype none

module flash_status_poller_asserts (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire flash_status_pkg::flash_addr_t flashAddr,
    input wire flash_status_pkg::flash_word_t flashDqOut,
    input wire logic flashDqOe,
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic flashWeN
);
    import flash_status_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    property p_ack_once; ack_o |=> !ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle");
    property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
    // ----------------------------------------
    // flash cycle shape
    // ----------------------------------------
    property p_no_fight; !(!flashOeN && !flashWeN); endproperty
    a_no_fight: assert property (p_no_fight) else $error("read and write strobes low together");
    property p_ce_strobe; (!flashOeN || !flashWeN) |-> !flashCeN; endproperty
    a_ce_strobe: assert property (p_ce_strobe) else $error("strobe without chip enable");
    property p_oe_width; $fell(flashOeN) |=> !flashOeN [*8] ##1 flashOeN; endproperty
    a_oe_width: assert property (p_oe_width) else $error("read strobe not nine cycles");
    property p_we_drive; !flashWeN |-> flashDqOe && $stable(flashDqOut); endproperty
    a_we_drive: assert property (p_we_drive) else $error("write data not driven steady");
    property p_addr_hold; !flashCeN && !$past(flashCeN) |-> $stable(flashAddr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved inside a cycle");
    property p_oe_release; !flashOeN |-> !flashDqOe; endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus driven during a read");
    // one idle cycle between flash cycles lets the toggle logic see a fresh read
    property p_gap; $rose(flashCeN) |=> flashCeN; endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle between flash cycles");
    c_write: cover property ($fell(flashWeN));
    c_read: cover property ($fell(flashOeN));
    c_ack: cover property (ack_o);
endmodule

bind flash_status_poller flash_status_poller_asserts u_chk (.mclk(mclk), .reset_n(reset_n), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN));
`default_nettype wire

// file: sim/flash_model.sv
// behavioural flash device answering status reads
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_regs.svh"

module flash_model #(
    parameter logic [15:0] ARRAY_WORD = 16'h5ac3,
    parameter int WINDOW_CYC = 200
) (
    input wire logic mclk,
    input wire logic [2:0] modeSet,
    input wire logic modeLoad,
    input wire flash_status_pkg::flash_word_t flashDqOut,
    input wire logic flashCeN,
    input wire logic flashOeN,
    input wire logic flashWeN,
    output flash_status_pkg::flash_word_t flashDqIn,
    output logic readyBusyN,
    output flash_status_pkg::flash_word_t lastCmd,
    output logic [7:0] cmdCount
);
    import flash_status_pkg::*;
    // modes: 0 array, 1 program, 2 timed out, 3 erase window, 4 erasing, 5 suspended
    logic [2:0] mode = 3'd0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic oePrev = 1'b1;
    logic wePrev = 1'b1;
    int timer = 0;
    flash_word_t st;
    flash_word_t word;
    flash_word_t held = 16'h0000;
    initial lastCmd = 16'h0000;
    initial cmdCount = 8'h00;
    always @(posedge mclk) begin
        oePrev <= flashOeN;
        wePrev <= flashWeN;
        if (modeLoad) begin
            mode <= modeSet;
            timer <= WINDOW_CYC;
        end else if (flashWeN && !wePrev) begin
            lastCmd <= flashDqOut;
            cmdCount <= cmdCount + 8'd1;
            if (flashDqOut == `FS_CMD_RESET) mode <= 3'd0;
            else if (mode == 3'd3) timer <= WINDOW_CYC;
            // anything else once erase has begun is dropped
        end else if (mode == 3'd3) begin
            if (timer == 0) mode <= 3'd4;
            else timer <= timer - 1;
        end
        if (flashOeN && !oePrev && mode inside {3'd1, 3'd2, 3'd3, 3'd4}) t1 <= ~t1;
        if (flashOeN && !oePrev && mode inside {3'd3, 3'd4, 3'd5}) t2 <= ~t2;
        if (!flashCeN && !flashOeN) held <= word;
    end
    always_comb begin
        st = 16'h0000;
        st[`FS_DQ_POLLING] = (mode == 3'd5);
        st[`FS_DQ_FIRST_TOGGLE] = t1;
        st[`FS_DQ_TIMEOUT] = (mode == 3'd2);
        st[`FS_DQ_ERASE_TIMER] = (mode == 3'd4);
        st[`FS_DQ_SECOND_TOGGLE] = t2;
    end
    assign word = (mode == 3'd0) ? ARRAY_WORD : st;
    // a released bus shows the inverse so stale data never looks valid
    assign flashDqIn = (!flashCeN && !flashOeN) ? word : ~held;
    assign readyBusyN = (mode == 3'd0) || (mode == 3'd5);
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the flash status poller
`timescale 1ns/100ps
`default_nettype none
`include "flash_status_regs.svh"
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    import flash_status_pkg::*;
    logic mclk, reset_n, cyc_i, stb_i, we_i, ack_o, flashDqOe, flashCeN, flashOeN, flashWeN, readyBusyN, modeLoad;
    logic [7:0] adr_i, cmdCount, n0;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rdq;
    logic [2:0] modeSet;
    flash_addr_t flashAddr;
    flash_word_t flashDqOut, flashDqIn, lastCmd;
    int bad_count = 0;
    int compares = 0;
    flash_status_poller DUT (.mclk(mclk), .reset_n(reset_n), .clkEn(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
        .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .readyBusyN(readyBusyN));
    flash_model #(.ARRAY_WORD(16'h5ac3), .WINDOW_CYC(200)) u_flash (.mclk(mclk), .modeSet(modeSet),
        .modeLoad(modeLoad), .flashDqOut(flashDqOut), .flashCeN(flashCeN), .flashOeN(flashOeN),
        .flashWeN(flashWeN), .flashDqIn(flashDqIn), .readyBusyN(readyBusyN), .lastCmd(lastCmd),
        .cmdCount(cmdCount));
    // ----------------------------------------
    // bus and helper tasks
    // ----------------------------------------
    // no answer time is assumed; a hung wait is ended by the watchdog
    task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
        do begin @(posedge mclk); end while (ack_o !== 1'b1);
        rdq = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        wbXfer(1'b0, a, 32'h0000_0000);
    endtask
    // leaves the final status word in rdq
    task automatic run(input logic [31:0] c);
        wbXfer(1'b1, `FS_OFF_CTRL, c);
        do begin rd(`FS_OFF_STATUS); end while (rdq[`FS_ST_BUSY] !== 1'b0);
    endtask
    task automatic setMode(input logic [2:0] m);
        modeSet <= m; modeLoad <= 1'b1;
        @(posedge mclk);
        modeLoad <= 1'b0;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(`FS_OFF_LIMIT); `CHECK("limit reset", 32'h0000_0000, rdq)
        rd(`FS_OFF_ADDR); `CHECK("addr reset", 32'h0000_0000, rdq)
        rd(8'h1C); `CHECK("unmapped read", 32'h0000_0000, rdq)
        wbXfer(1'b1, `FS_OFF_ADDR, 32'h0012_3456);
        rd(`FS_OFF_ADDR); `CHECK("addr readback", 32'h0012_3456, rdq)
        $display("test regs done");
    endtask
    task automatic t_done();
        setMode(3'd0);
        run(32'h0000_0001);
        `CHECK("done ok", 1'b1, rdq[`FS_ST_OK])
        `CHECK("done fail", 1'b0, rdq[`FS_ST_FAIL])
        `CHECK("done ready", 1'b1, rdq[`FS_ST_READY_PIN])
        rd(`FS_OFF_DATA); `CHECK("array word", 16'h5ac3, rdq[15:0])
        `CHECK("bank addr", 22'h12_3456, flashAddr)
        $display("test done-poll done");
    endtask
    task automatic t_fail();
        setMode(3'd2);
        run(32'h0000_0001);
        `CHECK("fail flag", 1'b1, rdq[`FS_ST_FAIL])
        `CHECK("fail ok", 1'b0, rdq[`FS_ST_OK])
        `CHECK("reset cmd", `FS_CMD_RESET, lastCmd)
        n0 = cmdCount;
        run(32'h0000_0004);
        `CHECK("reset only", n0 + 8'd1, cmdCount)
        $display("test timeout done");
    endtask
    task automatic t_left();
        setMode(3'd1);
        wbXfer(1'b1, `FS_OFF_LIMIT, 32'h0000_0002);
        run(32'h0000_0001);
        `CHECK("left flag", 1'b1, rdq[`FS_ST_LEFT])
        `CHECK("poll count", 16'h0002, rdq[31:16])
        `CHECK("left fail", 1'b0, rdq[`FS_ST_FAIL])
        wbXfer(1'b1, `FS_OFF_LIMIT, 32'h0000_0000);
        $display("test leave done");
    endtask
    task automatic t_suspend();
        setMode(3'd5);
        run(32'h0000_0001);
        `CHECK("susp ok", 1'b1, rdq[`FS_ST_OK])
        `CHECK("sector sel", 1'b1, rdq[`FS_ST_SECT_SEL])
        `CHECK("suspended", 1'b1, rdq[`FS_ST_SUSPENDED])
        $display("test suspend done");
    endtask
    task automatic t_erase();
        setMode(3'd0);
        run(32'h0000_0002);
        `CHECK("not accepted", 1'b1, rdq[`FS_ST_NOT_ACCEPTED])
        setMode(3'd3);
        run(32'h0000_0002);
        `CHECK("timer pre", 1'b0, rdq[`FS_ST_TIMER_PRE])
        `CHECK("timer post", 1'b0, rdq[`FS_ST_TIMER_POST])
        `CHECK("may reject", 1'b0, rdq[`FS_ST_MAY_REJECT])
        `CHECK("erase cmd", `FS_CMD_SECT_ERASE, lastCmd)
        setMode(3'd4);
        n0 = cmdCount;
        run(32'h0000_0002);
        `CHECK("timer pre hi", 1'b1, rdq[`FS_ST_TIMER_PRE])
        `CHECK("no cmd sent", n0, cmdCount)
        `CHECK("busy pin", 1'b0, rdq[`FS_ST_READY_PIN])
        run(32'h0000_000A);
        `CHECK("skip sends", n0 + 8'd1, cmdCount)
        $display("test erase done");
    endtask
    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        reset_n = 1'b0; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h0;
        dat_i = 32'h0000_0000; modeSet = 3'd0; modeLoad = 1'b0; rdq = 32'h0000_0000; n0 = 8'h00;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_done();
        t_fail();
        t_left();
        t_suspend();
        t_erase();
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
